// File: design/asq_sequencer.sv
// Multichannel scan sequencer with bias outputs, autoscan timer and result math.
// Summary of operation
// - Mode field picks scan, bias scan, autoscan.
// - Ready at scan end when option set.
// - Channel maps give channels, order, bias pins.
// - Scan and bias modes sleep when done.
// - Opcode 01 aborts to selected power-down.
// - Per-channel ready flags; pin per channel or per scan.
// - Single-cycle required; continuous bit ignored.
// - Bias scan drives pins, ignores direct.
// - Optional bias settle delay before mux.
// - Optional mux settle delay before conversion.
// - Autoscan repeats wait, scan, math, sleep.
// - Interval zero skips wait, else steps.
// - Sync produced only with nonzero interval.
// - IRQ status read clears autoscan pin unless FIFO irq.
// - Autoscan pin ignores end option; zero delay.
// - Method 00 checks result against bounds.
// - Method 01 checks difference to previous.
// - Method 01 write skips first check.
// - Method 10 checks high-pass filter output.
// - Method 10 write resets filter; 11 reserved.
// - Results and bounds are signed.
// - Power-down target 01 sleep, 10 standby.
// - Control write during conversion gives standby.
`include "asq_consts.svh"
module asq_sequencer #(
    parameter int AUTO_STEP_CYCLES = `ASQ_AUTO_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [3:0] cmd_rate,
    input wire logic fifo_irq,
    output logic conv_start,
    output logic [2:0] conv_channel,
    output logic [3:0] conv_rate,
    input wire logic conv_done,
    input wire asq_pkg::asq_sample_t conv_result,
    output logic [5:0] bias_output_pin,
    output logic ready_irq_n,
    output logic sync_out,
    output logic [1:0] pd_status
);
    import asq_pkg::*;

    asq_state_t state_r;
    logic [5:0] seq_r;
    logic [3:0] ctrl1_r;
    logic [23:0] delay_r;
    logic [5:0] pin_dir_r;
    logic [4:0] hpf_r;
    logic [23:0] map_lo_r, map_hi_r;
    asq_sample_t low_r [6];
    asq_sample_t high_r [6];
    asq_sample_t res_r [6];
    asq_sample_t lp_r [6];
    logic [5:0] first_r, srdy_r, oor_r;
    logic ready_r;
    logic [2:0] slot_r;
    logic [7:0] cnt_r;
    logic [31:0] step_r;
    logic step_tick;

    logic [1:0] scan_mode_select, powerdown_target, compare_method;
    logic ready_at_scan_end, mux_delay_enable, single_cycle_select;
    logic [7:0] mux_settle_delay, bias_settle_delay, autoscan_interval;
    logic wr_ctrl1, wr_hpf, rd_stat, rd_irq, running, start_cmd, pd_cmd, scan_end, ch_done;
    logic bias_dly_on;
    logic [3:0] found;
    logic [7:0] cur_map;
    logic oor_hit;

    assign scan_mode_select = seq_r[1:0];
    assign ready_at_scan_end = seq_r[`ASQ_SEQ_RDYEND];
    assign mux_delay_enable = seq_r[`ASQ_SEQ_MUXDLY];
    assign powerdown_target = ctrl1_r[1:0];
    assign single_cycle_select = ctrl1_r[`ASQ_SINGLE_CYCLE_SELECT];
    assign compare_method = hpf_r[1:0];
    assign mux_settle_delay = delay_r[7:0];
    assign bias_settle_delay = delay_r[`ASQ_DLY_BIAS_LSB +: 8];
    assign autoscan_interval = delay_r[`ASQ_DLY_AUTO_LSB +: 8];

    // Map byte of one channel: enable, order, bias enable, bias pin.
    function automatic logic [7:0] chan_map(input logic [23:0] lo, input logic [23:0] hi, input logic [2:0] ch);
        logic [7:0] m;
        m = 8'h00;
        if (ch < 3'h3) begin
            m = lo[ch * 8 +: 8];
        end else if (ch < 3'h6) begin
            m = hi[(ch - 3'h3) * 8 +: 8];
        end
        return m;
    endfunction

    // Finds the enabled channel that holds a conversion slot; bit 3 flags a hit.
    function automatic logic [3:0] slot_chan(input logic [23:0] lo, input logic [23:0] hi, input logic [2:0] slot);
        logic [3:0] r;
        logic [7:0] m;
        r = 4'h0;
        for (int c = 5; c >= 0; c--) begin
            m = chan_map(lo, hi, 3'(c));
            if (m[0] && m[3:1] == slot) begin
                r = {1'b1, 3'(c)};
            end
        end
        return r;
    endfunction

    // Signed window check of a 25-bit value against 24-bit bounds.
    function automatic logic outside(input logic signed [24:0] v, input asq_sample_t lo, input asq_sample_t hi);
        return (v < 25'(lo)) || (v > 25'(hi));
    endfunction

    assign found = slot_chan(map_lo_r, map_hi_r, slot_r);
    assign cur_map = chan_map(map_lo_r, map_hi_r, conv_channel);
    assign wr_ctrl1 = bus_wr && bus_addr == `ASQ_A_CTRL1;
    assign wr_hpf = bus_wr && bus_addr == `ASQ_A_HPF;
    assign rd_stat = bus_rd && bus_addr == `ASQ_A_STAT;
    assign rd_irq = bus_rd && bus_addr == `ASQ_A_IRQST;
    assign running = state_r != ST_SLEEP && state_r != ST_STBY;
    // The continuous bit is never looked at; a clear single-cycle bit refuses the start.
    assign start_cmd = cmd_valid && cmd_op == `ASQ_OP_CONV && !running && scan_mode_select != 2'b00
        && single_cycle_select;
    assign pd_cmd = cmd_valid && cmd_op == `ASQ_OP_PD;
    assign scan_end = (state_r == ST_PICK && !found[3] || ch_done) && slot_r == `ASQ_LAST_SLOT;
    assign ch_done = state_r == ST_MATH;
    assign bias_dly_on = (scan_mode_select == `ASQ_MODE_BIAS && seq_r[`ASQ_SEQ_DLY3])
        || (scan_mode_select == `ASQ_MODE_AUTO && seq_r[`ASQ_SEQ_DLY4]);

    always_ff @(posedge clk) begin
        if (srst) begin
            seq_r <= `ASQ_SEQ_RST;
            ctrl1_r <= `ASQ_CTRL1_RST;
            delay_r <= 24'h0;
            pin_dir_r <= 6'h00;
            hpf_r <= 5'h00;
            map_lo_r <= 24'h0;
            map_hi_r <= 24'h0;
            for (int i = 0; i < 6; i++) begin
                low_r[i] <= 24'h0;
                high_r[i] <= 24'h0;
            end
        end else if (bus_wr) begin
            unique case (bus_addr)
                `ASQ_A_SEQ: seq_r <= bus_wdata[5:0];
                `ASQ_A_CTRL1: ctrl1_r <= bus_wdata[3:0];
                `ASQ_A_DELAY: delay_r <= bus_wdata[23:0];
                `ASQ_A_PINDIR: pin_dir_r <= bus_wdata[5:0];
                `ASQ_A_HPF: hpf_r <= bus_wdata[4:0];
                `ASQ_A_MAPLO: map_lo_r <= bus_wdata[23:0];
                `ASQ_A_MAPHI: map_hi_r <= bus_wdata[23:0];
                default: begin
                    if (bus_addr[7:5] == `ASQ_A_LOW && bus_addr[4:2] < 3'h6) begin
                        low_r[bus_addr[4:2]] <= bus_wdata[23:0];
                    end
                    if (bus_addr[7:5] == `ASQ_A_HIGH && bus_addr[4:2] < 3'h6) begin
                        high_r[bus_addr[4:2]] <= bus_wdata[23:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_rdata <= 32'h0;
        end else begin
            bus_rdata <= 32'h0;
            if (bus_rd) begin
                unique case (bus_addr)
                    `ASQ_A_SEQ: bus_rdata <= {26'h0, seq_r};
                    `ASQ_A_CTRL1: bus_rdata <= {28'h0, ctrl1_r};
                    `ASQ_A_DELAY: bus_rdata <= {8'h0, delay_r};
                    `ASQ_A_PINDIR: bus_rdata <= {26'h0, pin_dir_r};
                    `ASQ_A_HPF: bus_rdata <= {27'h0, hpf_r};
                    `ASQ_A_STAT: bus_rdata <= {22'h0, pd_status, 2'b00, srdy_r};
                    `ASQ_A_IRQST: bus_rdata <= {26'h0, oor_r};
                    `ASQ_A_MAPLO: bus_rdata <= {8'h0, map_lo_r};
                    `ASQ_A_MAPHI: bus_rdata <= {8'h0, map_hi_r};
                    default: begin
                        if (bus_addr[4:2] < 3'h6) begin
                            if (bus_addr[7:5] == `ASQ_A_LOW) begin
                                bus_rdata <= {{8{low_r[bus_addr[4:2]][23]}}, low_r[bus_addr[4:2]]};
                            end else if (bus_addr[7:5] == `ASQ_A_HIGH) begin
                                bus_rdata <= {{8{high_r[bus_addr[4:2]][23]}}, high_r[bus_addr[4:2]]};
                            end else if (bus_addr[7:5] == `ASQ_A_DATA) begin
                                bus_rdata <= {{8{res_r[bus_addr[4:2]][23]}}, res_r[bus_addr[4:2]]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Autoscan step divider runs only while waiting, so each wait starts on a full step.
    always_ff @(posedge clk) begin
        if (srst || state_r != ST_WAIT || step_r == 32'(AUTO_STEP_CYCLES - 1)) begin
            step_r <= 32'h0;
        end else begin
            step_r <= step_r + 32'h1;
        end
    end
    assign step_tick = state_r == ST_WAIT && step_r == 32'(AUTO_STEP_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_SLEEP;
            slot_r <= 3'h0;
            cnt_r <= 8'h00;
            conv_start <= 1'b0;
            conv_channel <= 3'h0;
            conv_rate <= 4'h0;
            sync_out <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            sync_out <= 1'b0;
            if (pd_cmd) begin
                state_r <= (powerdown_target == `ASQ_PD_SLEEP) ? ST_SLEEP : ST_STBY;
            end else if (wr_ctrl1 && running) begin
                state_r <= ST_STBY;
            end else begin
                unique case (state_r)
                    ST_SLEEP, ST_STBY: begin
                        if (start_cmd) begin
                            state_r <= ST_PICK;
                            slot_r <= 3'h0;
                            conv_rate <= cmd_rate;
                            sync_out <= scan_mode_select == `ASQ_MODE_AUTO && autoscan_interval != 8'h00;
                        end
                    end
                    ST_WAIT: begin
                        if (step_tick) begin
                            if (cnt_r <= 8'h01) begin
                                state_r <= ST_PICK;
                                slot_r <= 3'h0;
                                sync_out <= autoscan_interval != 8'h00;
                            end else begin
                                cnt_r <= cnt_r - 8'h01;
                            end
                        end
                    end
                    ST_PICK: begin
                        if (found[3]) begin
                            conv_channel <= found[2:0];
                            state_r <= ST_BIAS;
                            cnt_r <= bias_dly_on ? bias_settle_delay : 8'h00;
                        end else if (slot_r != `ASQ_LAST_SLOT) begin
                            slot_r <= slot_r + 3'h1;
                        end else if (scan_mode_select != `ASQ_MODE_AUTO) begin
                            state_r <= ST_SLEEP;
                        end else if (autoscan_interval == 8'h00) begin
                            slot_r <= 3'h0;
                        end else begin
                            state_r <= ST_WAIT;
                            cnt_r <= autoscan_interval;
                        end
                    end
                    ST_BIAS: begin
                        if (cnt_r == 8'h00) begin
                            state_r <= ST_MUX;
                            cnt_r <= mux_delay_enable ? mux_settle_delay : 8'h00;
                        end else begin
                            cnt_r <= cnt_r - 8'h01;
                        end
                    end
                    ST_MUX: begin
                        if (cnt_r == 8'h00) begin
                            state_r <= ST_CONV;
                            conv_start <= 1'b1;
                        end else begin
                            cnt_r <= cnt_r - 8'h01;
                        end
                    end
                    ST_CONV: begin
                        if (conv_done) begin
                            state_r <= ST_MATH;
                        end
                    end
                    ST_MATH: begin
                        state_r <= ST_PICK;
                        slot_r <= slot_r + 3'h1;
                        // A channel in the last slot ends the scan here, as the slot count would wrap.
                        if (slot_r == `ASQ_LAST_SLOT) begin
                            if (scan_mode_select != `ASQ_MODE_AUTO) begin
                                state_r <= ST_SLEEP;
                            end else if (autoscan_interval != 8'h00) begin
                                state_r <= ST_WAIT;
                                cnt_r <= autoscan_interval;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign pd_status = state_r == ST_SLEEP || state_r == ST_WAIT ? `ASQ_PD_SLEEP :
        state_r == ST_STBY ? `ASQ_PD_STBY : `ASQ_PD_CONV;

    // Bias pins follow the current channel in bias and autoscan modes while converting; scan mode drives the direct register, else zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            bias_output_pin <= 6'h00;
        end else if (scan_mode_select == `ASQ_MODE_SCAN || !running) begin
            bias_output_pin <= scan_mode_select == `ASQ_MODE_SCAN ? pin_dir_r : 6'h00;
        end else if (state_r == ST_WAIT || state_r == ST_PICK) begin
            bias_output_pin <= 6'h00;
        end else begin
            bias_output_pin <= cur_map[4] && cur_map[7:5] < 3'h6 ? 6'(6'h01 << cur_map[7:5]) : 6'h00;
        end
    end

    // Result math per finished channel.
    logic signed [24:0] cur_ext, diff, hp_err, test_v;
    assign cur_ext = 25'(res_r[conv_channel]);
    assign diff = cur_ext - 25'(lp_r[conv_channel]);
    assign hp_err = cur_ext - 25'(lp_r[conv_channel]);
    always_comb begin
        test_v = cur_ext;
        if (compare_method == `ASQ_CMP_DIFF) begin
            test_v = diff;
        end else if (compare_method == `ASQ_CMP_HPF) begin
            test_v = hp_err;
        end
    end
    assign oor_hit = compare_method != 2'b11 && outside(test_v, low_r[conv_channel], high_r[conv_channel])
        && !(compare_method == `ASQ_CMP_DIFF && first_r[conv_channel]);

    // In difference mode the filter store holds the previous result instead.
    always_ff @(posedge clk) begin
        if (srst) begin
            first_r <= 6'h3f;
            for (int i = 0; i < 6; i++) begin
                res_r[i] <= 24'h0;
                lp_r[i] <= 24'h0;
            end
        end else begin
            if (state_r == ST_CONV && conv_done) begin
                res_r[conv_channel] <= conv_result;
            end
            if (ch_done) begin
                first_r[conv_channel] <= 1'b0;
                if (compare_method == `ASQ_CMP_HPF) begin
                    lp_r[conv_channel] <= lp_r[conv_channel]
                        + 24'(hp_err >>> (4'(hpf_r[`ASQ_HPF_FREQ_LSB +: 3]) + 4'h1));
                end else begin
                    lp_r[conv_channel] <= res_r[conv_channel];
                end
            end
            if (wr_hpf && bus_wdata[1:0] == `ASQ_CMP_DIFF) begin
                first_r <= 6'h3f;
            end
            if (wr_hpf && bus_wdata[1:0] == `ASQ_CMP_HPF) begin
                for (int i = 0; i < 6; i++) begin
                    lp_r[i] <= 24'h0;
                end
            end
        end
    end

    // Flags set by hardware win over a clearing read in the same cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            srdy_r <= 6'h00;
            oor_r <= 6'h00;
            ready_r <= 1'b0;
        end else begin
            srdy_r <= (rd_stat ? 6'h00 : srdy_r) | (ch_done ? 6'(6'h01 << conv_channel) : 6'h00);
            oor_r <= (rd_irq ? 6'h00 : oor_r)
                | (ch_done && oor_hit ? 6'(6'h01 << conv_channel) : 6'h00);
            ready_r <= (rd_stat ? 1'b0 : ready_r)
                | (ready_at_scan_end ? scan_end : ch_done);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ready_irq_n <= 1'b1;
        end else if (scan_mode_select == `ASQ_MODE_AUTO) begin
            ready_irq_n <= !((|oor_r && !rd_irq) || fifo_irq);
        end else begin
            ready_irq_n <= !ready_r;
        end
    end

    sequence mux_zero_s;
        state_r == ST_MUX && cnt_r == 8'h00 && !pd_cmd && !(wr_ctrl1 && running);
    endsequence
    sequence conv_go_s;
        conv_start && state_r == ST_CONV;
    endsequence
    property mux_then_conv_p;
        @(posedge clk) disable iff (srst) mux_zero_s |=> conv_go_s;
    endproperty
    mux_settle_a: assert property (mux_then_conv_p) else $error("conversion did not follow mux delay");
    conv_cause_a: assert property (@(posedge clk) disable iff (srst)
        conv_start |-> $past(state_r) == ST_MUX) else $error("conversion started outside mux wait");
    start_scan_a: assert property (@(posedge clk) disable iff (srst)
        start_cmd && !pd_cmd |=> pd_status == `ASQ_PD_CONV) else $error("scan not started");
    pd_abort_a: assert property (@(posedge clk) disable iff (srst)
        pd_cmd && powerdown_target == `ASQ_PD_STBY |=> state_r == ST_STBY) else $error("abort missed");
    ctrl_abort_a: assert property (@(posedge clk) disable iff (srst)
        wr_ctrl1 && running && !pd_cmd |=> state_r == ST_STBY) else $error("ctrl write kept running");
    scan_sleep_a: assert property (@(posedge clk) disable iff (srst)
        scan_end && scan_mode_select != `ASQ_MODE_AUTO && !pd_cmd && !wr_ctrl1 |=> state_r == ST_SLEEP)
        else $error("scan did not sleep");
    srdy_set_a: assert property (@(posedge clk) disable iff (srst)
        ch_done |=> srdy_r[$past(conv_channel)]) else $error("ready flag not set");
    end_ready_a: assert property (@(posedge clk) disable iff (srst)
        $rose(ready_r) && $past(ready_at_scan_end) |-> $past(scan_end)) else $error("early ready");
    sync_gate_a: assert property (@(posedge clk) disable iff (srst)
        sync_out |-> $past(autoscan_interval) != 8'h00) else $error("sync with zero interval");
    fifo_hold_a: assert property (@(posedge clk) disable iff (srst)
        scan_mode_select == `ASQ_MODE_AUTO && fifo_irq |=> !ready_irq_n) else $error("pin released");
endmodule

// File: common/asq_consts.svh
// Register offsets, field positions, codes and timing counts of the scan sequencer.
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH
`define ASQ_A_SEQ 8'h00
`define ASQ_A_CTRL1 8'h04
`define ASQ_A_DELAY 8'h08
`define ASQ_A_PINDIR 8'h0c
`define ASQ_A_HPF 8'h10
`define ASQ_A_STAT 8'h14
`define ASQ_A_IRQST 8'h18
`define ASQ_A_MAPLO 8'h20
`define ASQ_A_MAPHI 8'h24
`define ASQ_A_LOW 3'h2
`define ASQ_A_HIGH 3'h3
`define ASQ_A_DATA 3'h4
`define ASQ_SEQ_RDYEND 2
`define ASQ_SEQ_MUXDLY 3
`define ASQ_SEQ_DLY3 4
`define ASQ_SEQ_DLY4 5
`define ASQ_SINGLE_CYCLE_SELECT 2
`define ASQ_CONTINUOUS_SINGLE_CYCLE 3
`define ASQ_DLY_BIAS_LSB 8
`define ASQ_DLY_AUTO_LSB 16
`define ASQ_HPF_FREQ_LSB 2
`define ASQ_STAT_PD_LSB 8
`define ASQ_SEQ_RST 6'h00
`define ASQ_CTRL1_RST 4'h1
`define ASQ_MODE_SCAN 2'b01
`define ASQ_MODE_BIAS 2'b10
`define ASQ_MODE_AUTO 2'b11
`define ASQ_OP_PD 2'b01
`define ASQ_OP_CONV 2'b11
`define ASQ_PD_SLEEP 2'b01
`define ASQ_PD_STBY 2'b10
`define ASQ_PD_CONV 2'b00
`define ASQ_CMP_ABS 2'b00
`define ASQ_CMP_DIFF 2'b01
`define ASQ_CMP_HPF 2'b10
`define ASQ_LAST_SLOT 3'h7
`define ASQ_AUTO_STEP_MS 4
`define ASQ_CLK_MHZ 200
`define ASQ_AUTO_STEP_CYCLES (`ASQ_AUTO_STEP_MS * `ASQ_CLK_MHZ * 1000)
`endif

// File: common/asq_pkg.sv
// Types shared by the scan sequencer.
package asq_pkg;
    typedef enum logic [2:0] {ST_SLEEP, ST_STBY, ST_WAIT, ST_PICK, ST_BIAS, ST_MUX, ST_CONV, ST_MATH} asq_state_t;
    typedef logic signed [23:0] asq_sample_t;
endpackage

// File: tb/asq_conv_model.sv
// Behavioural converter that answers each conversion start after a set latency.
module asq_conv_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic conv_start,
    input wire logic [7:0] lat,
    input wire asq_pkg::asq_sample_t value,
    output logic conv_done,
    output asq_pkg::asq_sample_t conv_result
);
    timeunit 1ns;
    timeprecision 1ps;
    import asq_pkg::*;
    int cnt;
    asq_sample_t last;
    always_ff @(posedge clk) begin
        conv_done <= 1'h0;
        // The result bus carries no stale value outside the done pulse.
        conv_result <= ~last;
        if (srst) begin
            cnt <= 0;
            last <= '0;
        end else if (conv_start) begin
            cnt <= int'(lat) + 1;
        end else if (cnt == 1) begin
            conv_done <= 1'h1;
            conv_result <= value;
            last <= value;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// File: tb/adc_scan_sequencer_test.sv
// Self-checking bench of the scan sequencer.
module adc_scan_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import asq_pkg::*;
    logic clk = 1'h0, srst = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0, cmd_valid = 1'h0, fifo_irq = 1'h0;
    logic [7:0] bus_addr = 8'h0, lat = 8'h04;
    logic [31:0] bus_wdata = 32'h0, bus_rdata, d;
    logic [1:0] cmd_op = 2'h0, pd_status;
    logic [3:0] cmd_rate = 4'h0, conv_rate;
    logic conv_start, conv_done, ready_irq_n, sync_out;
    logic [2:0] conv_channel;
    logic [5:0] bias_output_pin;
    asq_sample_t conv_result, value = '0;
    int failures = 0, n_compared = 0, seed = 76, n, lp;
    always #2.5 clk = ~clk;
    asq_sequencer #(.AUTO_STEP_CYCLES(8)) i_dut (.clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .cmd_valid, .cmd_op, .cmd_rate, .fifo_irq, .conv_start, .conv_channel, .conv_rate,
        .conv_done, .conv_result, .bias_output_pin, .ready_irq_n, .sync_out, .pd_status);
    asq_conv_model i_conv (.clk, .srst, .conv_start, .lat, .value, .conv_done, .conv_result);
    task automatic test_done();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_wr <= 1'h1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_rd <= 1'h1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'h0;
        #1 d = bus_rdata;
    endtask
    task automatic cmd(input logic [1:0] op);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_rate <= 4'($random(seed));
        @(posedge clk);
        cmd_valid <= 1'h0;
    endtask
    task automatic wait_pd(input logic [1:0] v);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (pd_status === v) break;
        end
        chk("pd_status", 32'(v), 32'(pd_status));
        if (pd_status !== v) test_done();
    endtask
    task automatic count_sync();
        n = 0;
        repeat (200) begin
            @(posedge clk);
            #1;
            if (sync_out === 1'h1) n++;
        end
    endtask
    function automatic logic [31:0] out_of_range_flag(input asq_sample_t x);
        return (x < -24'sd100 || x > 24'sd100) ? 32'h3 : 32'h0;
    endfunction
    // Cycles from the start command to the first conversion start: pick, bias wait d+1, mux wait m+1.
    function automatic int start_cycles(input int d, input int m);
        return 3 + d + m;
    endfunction
    task automatic scan(input logic [31:0] e, input int ns, input logic [5:0] pins);
        cmd(2'b11);
        n = 0;
        while (n < 300 && conv_start !== 1'h1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("start_delay", 32'(ns), 32'(n));
        chk("bias_pin", 32'(pins), 32'(bias_output_pin));
        chk("first_channel", 32'h0, 32'(conv_channel));
        wait_pd(2'b01);
        chk("conv_rate", 32'(cmd_rate), 32'(conv_rate));
        chk("ready_irq_n", 32'h0, 32'(ready_irq_n));
        rd(8'h14);
        chk("stat", 32'h103, d);
        rd(8'h18);
        chk("oor", e, d);
        rd(8'h80);
        chk("result", {{8{value[23]}}, value}, d);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        rd(8'h04);
        chk("ctrl1", 32'h1, d);
        wr(8'h00, 32'h1);
        wr(8'h0c, 32'h2a);
        wr(8'h20, 32'h0301);
        wr(8'h40, 32'hffff9c);
        wr(8'h44, 32'hffff9c);
        wr(8'h60, 32'h64);
        wr(8'h64, 32'h64);
        cmd(2'b11);
        repeat (4) @(posedge clk);
        chk("refused", 32'h1, 32'(pd_status));
        wr(8'h04, 32'h5);
        for (int k = 0; k < 8; k++) begin
            value <= (k == 0) ? 24'sd100 : (k == 1) ? -24'sd101 : 24'($random(seed) % 200);
            @(posedge clk);
            scan(out_of_range_flag(value), start_cycles(0, 0), 6'h2a);
        end
        wr(8'h10, 32'h1);
        for (int k = 0; k < 3; k++) begin
            value <= (k == 2) ? 24'sd700 : 24'sd500;
            @(posedge clk);
            scan((k == 2) ? 32'h3 : 32'h0, start_cycles(0, 0), 6'h2a);
        end
        wr(8'h10, 32'h2);
        value <= 24'sd300;
        lp = 0;
        for (int k = 0; k < 3; k++) begin
            scan(out_of_range_flag(24'(300 - lp)), start_cycles(0, 0), 6'h2a);
            lp = lp + (300 - lp) / 2;
        end
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h1a);
        wr(8'h08, 32'h0305);
        wr(8'h20, 32'h9351);
        scan(out_of_range_flag(value), start_cycles(3, 5), 6'h04);
        lat <= 8'd200;
        wr(8'h04, 32'h6);
        cmd(2'b11);
        repeat (10) @(posedge clk);
        cmd(2'b01);
        wait_pd(2'b10);
        wr(8'h04, 32'h5);
        cmd(2'b11);
        repeat (10) @(posedge clk);
        wr(8'h04, 32'h5);
        wait_pd(2'b10);
        cmd(2'b01);
        wait_pd(2'b01);
        lat <= 8'h04;
        wr(8'h00, 32'h7);
        wr(8'h08, 32'h0);
        cmd(2'b11);
        count_sync();
        chk("sync_zero", 32'h0, 32'(n));
        chk("irq_auto", 32'h0, 32'(ready_irq_n));
        @(posedge clk);
        value <= '0;
        repeat (40) @(posedge clk);
        chk("irq_latched", 32'h0, 32'(ready_irq_n));
        rd(8'h18);
        chk("irq_flags", 32'h3, d);
        chk("irq_release", 32'h1, 32'(ready_irq_n));
        @(posedge clk);
        fifo_irq <= 1'h1;
        rd(8'h18);
        chk("irq_fifo", 32'h0, 32'(ready_irq_n));
        @(posedge clk);
        fifo_irq <= 1'h0;
        cmd(2'b01);
        wait_pd(2'b01);
        wr(8'h08, 32'h10000);
        cmd(2'b11);
        count_sync();
        chk("sync_run", 32'h1, 32'(n > 0));
        cmd(2'b01);
        wait_pd(2'b01);
        test_done();
    end
endmodule
